// ===== inc/szac_map.vh
// constants for the secure zone access control block
`ifndef SZAC_MAP_VH
`define SZAC_MAP_VH
`define SZAC_ZONES          8
`define SZAC_PW_SETS        8
`define SZAC_KEYS           4
`define SZAC_PAGE_BYTES     8
`define SZAC_AT_MAX_BYTES   4'h8
`define SZAC_TRIAL_LIMIT    3'h4
`define SZAC_LOCK_SELF_BIT  0
`define SZAC_MODE_STD       2'h0
`define SZAC_MODE_AUTH      2'h1
`define SZAC_MODE_ENC       2'h2
`define SZAC_CYC_NS         50
`define SZAC_WR_CYC         8'h10
`define SZAC_MEM_AW         10
`define SZAC_CHK_INIT       8'h00
`define SZAC_BUF_DEPTH      8
`endif

// ===== core/szac_tear_buf.v
// anti-tearing buffer zone and its commit state
`timescale 1ns/1ps
`include "szac_map.vh"
module szac_tear_buf #(
  parameter AW = `SZAC_MEM_AW
)
(
  input  wire          clk,
  input  wire          resetn,
  input  wire          clr,
  input  wire          load_en,
  input  wire [2:0]    load_idx,
  input  wire [7:0]    load_data,
  input  wire [AW-1:0] load_base,
  input  wire [3:0]    load_cnt,
  input  wire          arm,
  input  wire          done,
  output reg           pending_ff,
  output wire [7:0]    rd_data,
  input  wire [2:0]    rd_idx,
  output reg  [AW-1:0] base_ff,
  output reg  [3:0]    cnt_ff
);
  reg [7:0] buf_mem [0:`SZAC_BUF_DEPTH-1];
  assign rd_data = buf_mem[rd_idx];
  always @(posedge clk)
  begin
    if (load_en)
      buf_mem[load_idx] <= load_data;
  end
  // pending flag models the nonvolatile copy-in-progress marker
  // no reset: marker, base and count must survive a power loss
  always @(posedge clk)
  begin
    if (clr)
      pending_ff <= 1'b0;
    else if (arm)
    begin
      pending_ff <= 1'b1;
      base_ff    <= load_base;
      cnt_ff     <= load_cnt;
    end
    else if (done)
      pending_ff <= 1'b0;
  end
endmodule // szac_tear_buf

// ===== core/szac_core.v
// access control, write integrity and security state of the secure memory
`timescale 1ns/1ps
`include "szac_map.vh"
module szac_core #(
  parameter AW     = `SZAC_MEM_AW,
  parameter WR_CYC = `SZAC_WR_CYC
)
(
  input  wire          clk,
  input  wire          resetn,
  input  wire          rst_pin,
  input  wire          link_clk,
  input  wire          at_enable,
  input  wire [7:0]    zone_wlock,
  input  wire [7:0]    zone_mfb,
  input  wire [7:0]    zone_pgm_only,
  input  wire [7:0]    zone_enc_req,
  input  wire [7:0]    zone_pw_req,
  input  wire [23:0]   zone_pw_sel,
  input  wire [15:0]   zone_key_sel,
  input  wire          supervisor_en,
  input  wire [2:0]    supervisor_pw,
  input  wire          pw_req,
  input  wire [2:0]    pw_set,
  input  wire          pw_is_write,
  input  wire          pw_ok,
  input  wire          auth_req,
  input  wire [1:0]    auth_key,
  input  wire          auth_ok,
  input  wire          enc_req,
  input  wire          mac_chk,
  input  wire          mac_ok,
  input  wire          wr_start,
  input  wire [AW-1:0] wr_addr,
  input  wire          wr_byte_vld,
  input  wire [7:0]    wr_byte,
  input  wire          wr_end,
  input  wire          rd_req,
  input  wire [AW-1:0] rd_addr,
  output reg  [7:0]    rd_data_ff,
  output reg           rd_ok_ff,
  output wire          busy,
  output reg           cmd_fail_ff,
  output reg           cmd_done_ff,
  output reg  [1:0]    sec_mode_ff,
  output reg  [3:0]    pw_active_ff,
  output reg  [1:0]    auth_key_ff,
  output reg  [2:0]    trial_cnt_ff,
  output reg  [7:0]    checksum_ff,
  output wire          mac_required,
  output reg           link_edge_ff
);
  localparam S_IDLE = 3'h0;
  localparam S_RECV = 3'h1;
  localparam S_BUFW = 3'h2;
  localparam S_COPY = 3'h3;
  localparam S_DIRW = 3'h4;
  localparam S_RECO = 3'h5;
  localparam MEMN   = 1 << AW;

  reg [7:0]    mem [0:MEMN-1];
  reg [2:0]    state_ff;
  reg [2:0]    nxt_state;
  reg [7:0]    wcnt_ff;
  reg [3:0]    nbytes_ff;
  reg [AW-1:0] base_ff;
  reg [7:0]    stage_ff [0:`SZAC_BUF_DEPTH-1];
  reg [2:0]    idx_ff;
  reg          refused_ff;
  reg          rst_s1_ff;
  reg          rst_s2_ff;
  reg          lk_s1_ff;
  reg          lk_s2_ff;
  reg          lk_d_ff;
  reg          boot_ff;
  reg          pw_is_wr_ff;

  wire          sec_clr = rst_s2_ff;
  wire [2:0]    zone_w = wr_addr[AW-1:AW-3];
  wire [2:0]    zone_r = rd_addr[AW-1:AW-3];
  wire          tb_pending;
  wire [7:0]    tb_rd;
  wire [AW-1:0] tb_base;
  wire [3:0]    tb_cnt;
  wire [AW-1:0] cur_addr = base_ff + {{(AW-3){1'b0}}, idx_ff};
  wire [2:0]    cur_zone = cur_addr[AW-1:AW-3];
  wire [AW-1:0] lock_addr = {cur_addr[AW-1:3], 3'h0};
  wire [7:0]    lock_byte = mem[lock_addr];
  wire          trials_out = (trial_cnt_ff >= `SZAC_TRIAL_LIMIT);

  // pin inputs pass two flops before use
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
      lk_s1_ff  <= 1'b0;
      lk_s2_ff  <= 1'b0;
      lk_d_ff   <= 1'b0;
      link_edge_ff <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= rst_pin;
      rst_s2_ff <= rst_s1_ff;
      lk_s1_ff  <= link_clk;
      lk_s2_ff  <= lk_s1_ff;
      lk_d_ff   <= lk_s2_ff;
      link_edge_ff <= lk_s2_ff & ~lk_d_ff;
    end
  end

  // one password active; write password grants read, supervisor all
  function pw_grants;
    input [2:0] z;
    input       need_write;
    begin
      pw_grants = !zone_pw_req[z] ||
        (pw_active_ff[3] &&
         (pw_active_ff[2:0] == zone_pw_sel[z*3 +: 3] ||
          (supervisor_en && pw_active_ff[2:0] == supervisor_pw)) &&
         (pw_is_wr_ff || !need_write));
    end
  endfunction

  // zone key must match the authenticated key
  function key_grants;
    input [2:0] z;
    begin
      key_grants = (sec_mode_ff != `SZAC_MODE_STD) &&
                   (auth_key_ff == zone_key_sel[z*2 +: 2]);
    end
  endfunction

  function enc_grants;
    input [2:0] z;
    begin
      enc_grants = !zone_enc_req[z] ||
        ((sec_mode_ff == `SZAC_MODE_ENC) && key_grants(z));
    end
  endfunction

  // secure modes demand a message code on every command
  assign mac_required = (sec_mode_ff != `SZAC_MODE_STD);

  // security state: passwords, authentication, trials, mode
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sec_mode_ff  <= `SZAC_MODE_STD;
      pw_active_ff <= 4'h0;
      pw_is_wr_ff  <= 1'b0;
      auth_key_ff  <= 2'h0;
      trial_cnt_ff <= 3'h0;
    end
    // reset pin clears password and authentication
    else if (sec_clr)
    begin
      sec_mode_ff  <= `SZAC_MODE_STD;
      pw_active_ff <= 4'h0;
      pw_is_wr_ff  <= 1'b0;
    end
    // bad message code drops back to standard mode
    else if (mac_chk && mac_required && !mac_ok)
      sec_mode_ff <= `SZAC_MODE_STD;
    // attempts ignored once trial limit reached
    else if (pw_req && !trials_out)
    begin
      // new password replaces old, failure clears it
      pw_active_ff <= {pw_ok, pw_set};
      pw_is_wr_ff  <= pw_is_write;
      trial_cnt_ff <= pw_ok ? 3'h0 : trial_cnt_ff + 3'h1;
    end
    else if (auth_req && !trials_out)
    begin
      sec_mode_ff  <= auth_ok ? `SZAC_MODE_AUTH : `SZAC_MODE_STD;
      auth_key_ff  <= auth_key;
      trial_cnt_ff <= auth_ok ? 3'h0 : trial_cnt_ff + 3'h1;
    end
    else if (enc_req && sec_mode_ff == `SZAC_MODE_AUTH)
      sec_mode_ff <= `SZAC_MODE_ENC;
  end

  // host may choose encryption mode for any zone it is keyed for
  wire rd_allow = pw_grants(zone_r, 1'b0) && enc_grants(zone_r);

  // command sequencer
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE:
        if (boot_ff && tb_pending)
          nxt_state = S_RECO;
        else if (wr_start)
          nxt_state = S_RECV;
      S_RECV:
        if (wr_end)
        begin
          if (refused_ff || nbytes_ff == 4'h0)
            nxt_state = S_IDLE;
          // buffered path when anti-tearing is on
          else if (at_enable)
            nxt_state = S_BUFW;
          else
            nxt_state = S_DIRW;
        end
      S_BUFW:
        if (wcnt_ff == 8'h00)
          nxt_state = S_COPY;
      S_COPY:
        if (wcnt_ff == 8'h00)
          nxt_state = S_IDLE;
      S_DIRW:
        if (wcnt_ff == 8'h00)
          nxt_state = S_IDLE;
      S_RECO:
        if (wcnt_ff == 8'h00)
          nxt_state = S_IDLE;
      default:
        nxt_state = S_IDLE;
    endcase
  end

  assign busy = (state_ff != S_IDLE) && (state_ff != S_RECV);

  wire write_phase = (state_ff == S_COPY || state_ff == S_DIRW ||
                      state_ff == S_RECO) && wcnt_ff == 8'h00;
  wire [7:0] src_byte = (state_ff == S_DIRW) ? stage_ff[idx_ff] : tb_rd;
  wire [7:0] old_byte = mem[cur_addr];
  reg  [7:0] new_byte;
  reg        byte_ok;

  // per-byte protection filter
  always @*
  begin
    new_byte = src_byte;
    byte_ok  = 1'b1;
    // program-only can clear bits but never set them outside recovery
    if (zone_pgm_only[cur_zone])
      new_byte = old_byte & src_byte;
    if (zone_wlock[cur_zone])
    begin
      // lock byte bits only move toward zero outside recovery
      if (cur_addr[2:0] == 3'h0)
      begin
        new_byte = old_byte & src_byte;
        byte_ok  = lock_byte[`SZAC_LOCK_SELF_BIT];
      end
      // zero bit in lock byte blocks its byte
      else
        byte_ok = lock_byte[cur_addr[2:0]];
    end
    // recovery replays the buffered copy unchanged
    if (state_ff == S_RECO)
    begin
      new_byte = src_byte;
      byte_ok  = 1'b1;
    end
  end

  wire [3:0] max_bytes = at_enable ? `SZAC_AT_MAX_BYTES : 4'h8;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff    <= S_IDLE;
      wcnt_ff     <= 8'h00;
      nbytes_ff   <= 4'h0;
      base_ff     <= {AW{1'b0}};
      idx_ff      <= 3'h0;
      refused_ff  <= 1'b0;
      cmd_fail_ff <= 1'b0;
      cmd_done_ff <= 1'b0;
      boot_ff     <= 1'b1;
      checksum_ff <= `SZAC_CHK_INIT;
    end
    else
    begin
      state_ff    <= nxt_state;
      cmd_done_ff <= 1'b0;
      boot_ff     <= 1'b0;
      if (state_ff != nxt_state)
        wcnt_ff <= WR_CYC;
      else if (wcnt_ff != 8'h00)
        wcnt_ff <= wcnt_ff - 8'h01;
      case (state_ff)
        S_IDLE:
          if (wr_start && !(boot_ff && tb_pending))
          begin
            base_ff     <= wr_addr;
            nbytes_ff   <= 4'h0;
            idx_ff      <= 3'h0;
            cmd_fail_ff <= 1'b0;
            checksum_ff <= `SZAC_CHK_INIT;
            refused_ff <= zone_mfb[zone_w] ||
                          !pw_grants(zone_w, 1'b1) ||
                          !enc_grants(zone_w);
          end
          else if (boot_ff && tb_pending)
          begin
            base_ff   <= tb_base;
            nbytes_ff <= tb_cnt;
            idx_ff    <= 3'h0;
          end
        S_RECV:
        begin
          // write-lock zones keep only the first byte
          if (wr_byte_vld && nbytes_ff < max_bytes &&
              !(zone_wlock[base_ff[AW-1:AW-3]] && nbytes_ff != 4'h0))
          begin
            stage_ff[nbytes_ff[2:0]] <= wr_byte;
            nbytes_ff <= nbytes_ff + 4'h1;
          end
          // checksum over received data for the host to read
          if (wr_byte_vld)
            checksum_ff <= {checksum_ff[6:0], checksum_ff[7]} ^ wr_byte;
          if (wr_end)
          begin
            cmd_fail_ff <= refused_ff;
            cmd_done_ff <= refused_ff || nbytes_ff == 4'h0;
          end
        end
        S_COPY, S_DIRW, S_RECO:
          if (write_phase)
          begin
            // blocked bytes keep their stored value
            if (byte_ok)
              mem[cur_addr] <= new_byte;
            else
              cmd_fail_ff <= 1'b1;
            if ({1'b0, idx_ff} + 4'h1 < nbytes_ff)
            begin
              idx_ff   <= idx_ff + 3'h1;
              state_ff <= state_ff;
              wcnt_ff  <= WR_CYC;
            end
            else
              cmd_done_ff <= 1'b1;
          end
        default:
          idx_ff <= idx_ff;
      endcase
    end
  end

  // copy marker is armed on the first cycle of the buffer write phase
  wire buf_load = (state_ff == S_BUFW) && (wcnt_ff == WR_CYC);

  szac_tear_buf #(
    .AW (AW)
  ) u_tear (
    .clk        (clk),
    .resetn     (resetn),
    .clr        (1'b0),
    .load_en    (state_ff == S_RECV && wr_byte_vld && !refused_ff &&
                 nbytes_ff < max_bytes),
    .load_idx   (nbytes_ff[2:0]),
    .load_data  (wr_byte),
    .load_base  (base_ff),
    .load_cnt   (nbytes_ff),
    // copy armed only once buffer is complete
    .arm        (buf_load),
    // marker cleared only after final copied byte
    .done       (cmd_done_ff && !refused_ff),
    .pending_ff (tb_pending),
    .rd_data    (tb_rd),
    .rd_idx     (idx_ff),
    .base_ff    (tb_base),
    .cnt_ff     (tb_cnt)
  );

  // read path
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_data_ff <= 8'h00;
      rd_ok_ff   <= 1'b0;
    end
    else if (rd_req)
    begin
      rd_ok_ff   <= rd_allow;
      rd_data_ff <= rd_allow ? mem[rd_addr] : 8'h00;
    end
  end
endmodule // szac_core

// ===== sim/szac_core_properties.sv
// concurrent checks on the ports of the access control core
`timescale 1ns/1ps
`include "szac_map.vh"
module szac_core_properties #(
  parameter AW     = 10,
  parameter WR_CYC = 8'h10
)
(
  input wire          clk,
  input wire          resetn,
  input wire          rst_pin,
  input wire          pw_req,
  input wire [2:0]    pw_set,
  input wire          pw_ok,
  input wire          auth_req,
  input wire [1:0]    auth_key,
  input wire          auth_ok,
  input wire          enc_req,
  input wire          mac_chk,
  input wire          mac_ok,
  input wire          wr_start,
  input wire [AW-1:0] wr_addr,
  input wire          wr_end,
  input wire [7:0]    zone_mfb,
  input wire          busy,
  input wire          cmd_fail_ff,
  input wire          cmd_done_ff,
  input wire [1:0]    sec_mode_ff,
  input wire [3:0]    pw_active_ff,
  input wire [1:0]    auth_key_ff,
  input wire [2:0]    trial_cnt_ff,
  input wire          mac_required
);
  reg  mfb_cmd_ff;
  wire open_trial = trial_cnt_ff < `SZAC_TRIAL_LIMIT;
  // remembers whether the accepted command targets a frozen zone
  always @(posedge clk or negedge resetn)
    if (!resetn)
      mfb_cmd_ff <= 1'b0;
    else if (wr_start && !busy)
      mfb_cmd_ff <= zone_mfb[wr_addr[AW-1:AW-3]];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_pw_try; pw_req && open_trial; endsequence
  sequence s_auth_try; auth_req && open_trial; endsequence
  sequence s_pin_held; rst_pin [*4]; endsequence
  a_mac_mode: assert property ( // code use
    mac_required == (sec_mode_ff != `SZAC_MODE_STD))
    else $error("mac flag disagrees with mode");
  a_mfb_refused: assert property ( // frozen zone
    wr_end && mfb_cmd_ff |=> ##[0:1] (cmd_done_ff && cmd_fail_ff))
    else $error("frozen zone write not refused");
  a_done_pulse: assert property ( // completion
    cmd_done_ff |=> !cmd_done_ff)
    else $error("done longer than one cycle");
  a_pw_grant: assert property ( // password kept
    s_pw_try and pw_ok |=> pw_active_ff == {1'b1, $past(pw_set)})
    else $error("password not taken");
  a_pw_fail: assert property ( // failed trial
    s_pw_try and !pw_ok |=> !pw_active_ff[3]
      && trial_cnt_ff == $past(trial_cnt_ff) + 3'h1)
    else $error("failed password not counted");
  a_limit_lock: assert property ( // trials spent
    (pw_req || auth_req) && !open_trial
      |=> $stable(pw_active_ff) && $stable(sec_mode_ff))
    else $error("attempt honoured after trial limit");
  a_trial_cap: assert property ( // trial bound
    trial_cnt_ff <= `SZAC_TRIAL_LIMIT)
    else $error("trial counter beyond limit");
  a_auth_grant: assert property ( // key chosen
    s_auth_try and auth_ok |=> sec_mode_ff == `SZAC_MODE_AUTH
      && auth_key_ff == $past(auth_key))
    else $error("authentication not entered");
  a_auth_loss: assert property ( // failed attempt
    s_auth_try and !auth_ok |=> sec_mode_ff == `SZAC_MODE_STD)
    else $error("failed authentication kept mode");
  a_enc_order: assert property ( // mode order
    sec_mode_ff == `SZAC_MODE_STD && enc_req
      |=> sec_mode_ff != `SZAC_MODE_ENC)
    else $error("encryption without authentication");
  a_mac_drop: assert property ( // bad code
    mac_chk && !mac_ok && mac_required |=> sec_mode_ff == `SZAC_MODE_STD)
    else $error("bad code kept secure mode");
  a_pin_clear: assert property ( // reset pin
    s_pin_held |=> sec_mode_ff == `SZAC_MODE_STD && !pw_active_ff[3])
    else $error("reset pin left security state");
endmodule // szac_core_properties
bind szac_core szac_core_properties #(.AW(AW), .WR_CYC(WR_CYC)) u_props (
  .clk(clk), .resetn(resetn), .rst_pin(rst_pin), .pw_req(pw_req),
  .pw_set(pw_set), .pw_ok(pw_ok), .auth_req(auth_req),
  .auth_key(auth_key), .auth_ok(auth_ok), .enc_req(enc_req),
  .mac_chk(mac_chk), .mac_ok(mac_ok), .wr_start(wr_start),
  .wr_addr(wr_addr), .wr_end(wr_end), .zone_mfb(zone_mfb), .busy(busy),
  .cmd_fail_ff(cmd_fail_ff), .cmd_done_ff(cmd_done_ff),
  .sec_mode_ff(sec_mode_ff), .pw_active_ff(pw_active_ff),
  .auth_key_ff(auth_key_ff), .trial_cnt_ff(trial_cnt_ff),
  .mac_required(mac_required));

// ===== sim/szac_host_link.sv
// host side link clock source, idle low between frames
`timescale 1ns/1ps
module szac_host_link #(
  parameter HALF_NS = 200
)
(
  input  wire frame,
  output reg  link_clk
);
  initial link_clk = 1'b0;
  always
  begin
    wait (frame);
    #HALF_NS link_clk = 1'b1;
    #HALF_NS link_clk = 1'b0;
  end
endmodule // szac_host_link

// ===== sim/tb.sv
// self-checking bench for the access control core
`timescale 1ns/1ps
module tb;
  reg         clk = 1'b0, resetn = 1'b0, rst_pin = 1'b0, frame = 1'b0;
  reg         at_enable = 1'b0, supervisor_en = 1'b0, pw_is_write = 1'b1;
  reg  [7:0]  zone_wlock = 8'h00, zone_mfb = 8'h00, zone_pgm_only = 8'h00;
  reg  [7:0]  zone_enc_req = 8'h20, zone_pw_req = 8'h10;
  reg  [23:0] zone_pw_sel = 24'h002000;
  reg  [15:0] zone_key_sel = 16'h0800;
  reg  [2:0]  supervisor_pw = 3'h0, pw_set = 3'h0;
  reg         pw_req = 0, pw_ok = 0, auth_req = 0, auth_ok = 0, enc_req = 0;
  reg         mac_chk = 0, mac_ok = 0, wr_start = 0, wr_byte_vld = 0;
  reg         wr_end = 0, rd_req = 0;
  reg  [1:0]  auth_key = 2'h0;
  reg  [9:0]  wr_addr = 10'h000, rd_addr = 10'h000;
  reg  [7:0]  wr_byte = 8'h00;
  reg  [7:0]  wbuf [0:7];
  reg  [3:0]  j;
  wire [7:0]  rd_data_ff, checksum_ff;
  wire        rd_ok_ff, busy, cmd_fail_ff, cmd_done_ff, mac_required;
  wire        link_clk, link_edge_ff;
  wire [1:0]  sec_mode_ff, auth_key_ff;
  wire [3:0]  pw_active_ff;
  wire [2:0]  trial_cnt_ff;
  integer     n_errors = 0, num_checks = 0, cyc = 0, i, k, e;
  always #25 clk = ~clk;
  szac_host_link u_link (.frame(frame), .link_clk(link_clk));
  szac_core #(.AW(10), .WR_CYC(8'h02)) u_dut (
    .clk(clk), .resetn(resetn), .rst_pin(rst_pin), .link_clk(link_clk),
    .at_enable(at_enable), .zone_wlock(zone_wlock), .zone_mfb(zone_mfb),
    .zone_pgm_only(zone_pgm_only), .zone_enc_req(zone_enc_req),
    .zone_pw_req(zone_pw_req), .zone_pw_sel(zone_pw_sel),
    .zone_key_sel(zone_key_sel), .supervisor_en(supervisor_en),
    .supervisor_pw(supervisor_pw), .pw_req(pw_req), .pw_set(pw_set),
    .pw_is_write(pw_is_write), .pw_ok(pw_ok), .auth_req(auth_req),
    .auth_key(auth_key), .auth_ok(auth_ok), .enc_req(enc_req),
    .mac_chk(mac_chk), .mac_ok(mac_ok), .wr_start(wr_start),
    .wr_addr(wr_addr), .wr_byte_vld(wr_byte_vld), .wr_byte(wr_byte),
    .wr_end(wr_end), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_data_ff(rd_data_ff), .rd_ok_ff(rd_ok_ff), .busy(busy),
    .cmd_fail_ff(cmd_fail_ff), .cmd_done_ff(cmd_done_ff),
    .sec_mode_ff(sec_mode_ff), .pw_active_ff(pw_active_ff),
    .auth_key_ff(auth_key_ff), .trial_cnt_ff(trial_cnt_ff),
    .checksum_ff(checksum_ff), .mac_required(mac_required),
    .link_edge_ff(link_edge_ff));
  task print_verdict;
  begin
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      n_errors = n_errors + 1;
      print_verdict;
    end
  end
  task tick;
  begin
    @(posedge clk);
    #5;
  end
  endtask
  task chk(input [8:0] got, input [8:0] exp);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task idle;
  begin
    k = 0;
    while (busy !== 1'b0 && k < 400)
    begin
      tick;
      k = k + 1;
    end
    chk({8'h00, busy}, 9'h000);
  end
  endtask
  task fill(input [7:0] b);
    for (i = 0; i < 8; i = i + 1)
      wbuf[i] = b + i[7:0];
  endtask
  task wr_send(input [9:0] a, input [3:0] n);
  begin
    idle; // ack poll
    wr_start = 1'b1;
    wr_addr = a;
    for (i = 0; i < n; i = i + 1)
    begin
      tick;
      wr_start = 1'b0;
      wr_byte_vld = 1'b1;
      wr_byte = wbuf[i];
    end
    tick;
    wr_start = 1'b0;
    wr_byte_vld = 1'b0;
    wr_end = 1'b1;
    tick;
    wr_end = 1'b0;
  end
  endtask
  // fail: bit0 expected refusal, bit1 refusal flag not judged
  task wr(input [9:0] a, input [3:0] n, input [1:0] fail);
  begin
    wr_send(a, n);
    k = 0;
    while (cmd_done_ff !== 1'b1 && k < 400)
    begin
      tick;
      k = k + 1;
    end
    chk({7'h00, cmd_done_ff, fail[1] ? fail[0] : cmd_fail_ff},
        {8'h01, fail[0]});
  end
  endtask
  task rd(input [9:0] a, input [7:0] x);
  begin
    rd_req = 1'b1;
    rd_addr = a;
    tick;
    rd_req = 1'b0;
    chk({rd_ok_ff, rd_data_ff}, {1'b1, x});
    tick;
  end
  endtask
  // kind: 0 password, 1 authentication, 2 encryption, 3 code check
  task sec(input [1:0] kind, input [2:0] v, input ok);
  begin
    pw_set = v;
    auth_key = v[1:0];
    pw_ok = ok;
    auth_ok = ok;
    mac_ok = ok;
    pw_req = (kind == 2'h0);
    auth_req = (kind == 2'h1);
    enc_req = (kind == 2'h2);
    mac_chk = (kind == 2'h3);
    tick;
    pw_req = 1'b0;
    auth_req = 1'b0;
    enc_req = 1'b0;
    mac_chk = 1'b0;
    tick;
  end
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    #5 resetn = 1'b1;
    tick;
    idle; // power-up poll
    e = 0;
    frame = 1'b1;
    for (k = 0; k < 40; k = k + 1)
    begin
      tick;
      if (k == 30)
        frame = 1'b0;
      if (link_edge_ff === 1'b1)
        e = e + 1;
    end
    chk(e[8:0], 9'h004);
    $display("test link edges done");
    fill(8'h30);
    wr(10'h000, 4'h2, 2'h0);
    chk({1'b0, checksum_ff}, 9'h051); // rotate-xor checksum
    rd(10'h000, 8'h30);
    rd(10'h001, 8'h31);
    $display("test plain write done");
    fill(8'h40);
    wr(10'h080, 4'h1, 2'h0);
    zone_mfb = 8'h02;
    fill(8'h55);
    wr(10'h080, 4'h1, 2'h1); // frozen
    rd(10'h080, 8'h40); // unchanged
    zone_mfb = 8'h00;
    $display("test modify forbidden done");
    fill(8'hf0);
    wr(10'h100, 4'h1, 2'h0);
    zone_pgm_only = 8'h04;
    fill(8'h3c);
    wr(10'h100, 4'h1, 2'h0);
    rd(10'h100, 8'h30); // clear only
    $display("test program only done");
    fill(8'hd9);
    wr(10'h180, 4'h8, 2'h0);
    zone_wlock = 8'h08;
    fill(8'h05);
    wr(10'h181, 4'h1, 2'h1); // blocked byte reported
    rd(10'h181, 8'hda); // locked byte
    wr(10'h183, 4'h2, 2'h0);
    rd(10'h183, 8'h05); // open byte
    rd(10'h184, 8'hdd); // first byte only
    wr(10'h180, 4'h1, 2'h0);
    rd(10'h180, 8'h01); // one way
    $display("test write lock done");
    at_enable = 1'b1;
    fill(8'h60);
    wr(10'h008, 4'h8, 2'h0); // eight bytes
    for (j = 4'h0; j < 4'h8; j = j + 4'h1)
      rd(10'h008 + {6'h00, j}, 8'h60 + {4'h0, j}); // buffered
    fill(8'h90);
    wr_send(10'h010, 4'h8);
    repeat (12) tick;
    chk({8'h00, busy}, 9'h001); // still copying
    resetn = 1'b0;
    tick;
    resetn = 1'b1;
    tick;
    idle; // recovery poll
    for (j = 4'h0; j < 4'h8; j = j + 4'h1)
      rd(10'h010 + {6'h00, j}, 8'h90 + {4'h0, j}); // replayed
    $display("test recovery done");
    at_enable = 1'b0;
    $display("test anti tearing done");
    fill(8'h70);
    wr(10'h200, 4'h1, 2'h1); // no password
    sec(2'h0, 3'h2, 1'b1);
    chk({5'h00, pw_active_ff}, 9'h00a); // kept
    wr(10'h200, 4'h1, 2'h0);
    rd(10'h200, 8'h70); // write grants read
    $display("test password done");
    fill(8'h80);
    wr(10'h280, 4'h1, 2'h1); // needs encryption
    sec(2'h1, 3'h2, 1'b1);
    chk({4'h0, mac_required, auth_key_ff, sec_mode_ff}, 9'h019);
    sec(2'h2, 3'h0, 1'b1);
    chk({7'h00, sec_mode_ff}, 9'h002); // encryption
    wr(10'h280, 4'h1, 2'h0); // allowed
    rd(10'h280, 8'h80);
    rd(10'h000, 8'h30); // encryption optional
    sec(2'h3, 3'h0, 1'b0);
    chk({7'h00, sec_mode_ff}, 9'h000); // bad code
    rd_req = 1'b1;
    rd_addr = 10'h280;
    tick;
    rd_req = 1'b0;
    chk({rd_ok_ff, rd_data_ff}, 9'h000); // refused read
    tick;
    sec(2'h1, 3'h1, 1'b1);
    sec(2'h1, 3'h1, 1'b0);
    chk({7'h00, sec_mode_ff}, 9'h000); // lost
    sec(2'h2, 3'h0, 1'b1);
    chk({7'h00, sec_mode_ff}, 9'h000); // no encryption first
    $display("test authentication done");
    sec(2'h1, 3'h0, 1'b1);
    rst_pin = 1'b1;
    repeat (4) tick;
    rst_pin = 1'b0;
    repeat (3) tick;
    chk({6'h00, pw_active_ff[3], sec_mode_ff}, 9'h000); // pin
    $display("test reset pin done");
    for (e = 0; e < 4; e = e + 1)
      sec(2'h0, 3'h1, 1'b0);
    chk({6'h00, trial_cnt_ff}, 9'h004); // limit
    sec(2'h0, 3'h3, 1'b1);
    sec(2'h1, 3'h0, 1'b1);
    chk({6'h00, pw_active_ff[3], sec_mode_ff}, 9'h000); // ignored
    $display("test trial limit done");
    print_verdict;
  end
endmodule // tb
